// File: src/sipc_bus_fold.sv
/*
  Folds the 32 peripheral bus request levels onto the eight internal levels
  and keeps the bridge pending vector.
  Assumes requests are synchronous to ref_clk and are levels held until
  serviced at their source.
*/
`timescale 1ns/1ps

module sipc_bus_fold
    import sipc_pkg::*;
#(
    parameter int BUS_LEVELS = `SIPC_NUM_BUS_LEVELS
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Peripheral bus side
    input wire sipc_pkg::sipc_bus_t busRequest,
    // Folded result
    output sipc_pkg::sipc_levels_t busLevel,
    output sipc_pkg::sipc_bus_t bridgePendingVector
);
    import sipc_pkg::*;

    sipc_bus_t pending;
    sipc_bus_t next_pending;

    always_comb begin
        next_pending = busRequest;
    end

    // Pending vector for software to find the true source
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pending <= '0;
        end else begin
            pending <= next_pending;
        end
    end

    assign bridgePendingVector = pending;

    always_comb begin
        busLevel = '0;
        // Levels 0..6 one for one
        for (int i = 0; i < `SIPC_FOLD_LEVEL; i++) begin
            busLevel[i] = pending[i];
        end
        // Levels 7..31 all onto level 7
        busLevel[`SIPC_FOLD_LEVEL] = |pending[BUS_LEVELS-1:`SIPC_FOLD_LEVEL];
    end

    // Checked against the raw requests, one register stage back
    foldLow_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        1'b1 |=> busLevel[6:0] == $past(busRequest[6:0]))
        else $error("low bus levels not mapped one for one");
    foldHigh_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        $rose(busRequest[20]) |=> busLevel[7])
        else $error("high bus level not folded onto level 7");
endmodule

// File: src/sipc_controller.sv
/*
  Interrupt priority controller: merges pins, internal sources and folded
  peripheral bus levels into one request toward the processor core, and
  encodes the highest-ranked pending source.
  Assumes one clock, synchronous inputs, active-low request pins already
  sampled, and a core that takes reset or external interrupt as signalled.
*/
// Function
// - Watchdog or pin 0 interrupt goes out as non-maskable, never maskable.
// - Non-maskable enters core reset interrupt; others take external interrupt.
// - Pins 1 to 7 each hold a fixed priority level.
// - Eight internal levels; software routes each source to any level.
// - Combined core request optionally copied onto request output pin.
// - Peripheral bus has 32 levels; any source configurable to any.
// - Bus levels 0 to 6 drive internal levels 0 to 6.
// - Bus levels 7 to 31 combine onto internal level 7.
// - Bridge holds 32-bit pending vector for software to read.
// - Fifteen maskable sources merge into one request line.
// - Pin n above level n; code is four times rank.
`timescale 1ns/1ps

module sipc_controller
    import sipc_pkg::*;
#(
    parameter int NUM_SRC = 8,
    parameter int BUS_LEVELS = `SIPC_NUM_BUS_LEVELS
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // External request pins, active low
    input wire sipc_pkg::sipc_pins_t irqPin_n,
    // Watchdog interrupt request and its interrupt-mode select
    input wire logic softwareWatchdogExpired,
    input wire logic softwareWatchdogIntMode,
    // Internal system sources and their level routing
    input wire logic [NUM_SRC-1:0] sysSourceReq,
    input wire logic [NUM_SRC*`SIPC_SEL_W-1:0] sysSourceSel,
    // Peripheral bus requests
    input wire sipc_pkg::sipc_bus_t busRequest,
    // Source enables: pins then levels
    input wire sipc_pkg::sipc_pins_t pinEnable,
    input wire sipc_pkg::sipc_levels_t levelEnable,
    input wire logic irqOutEnable,
    // Toward the processor core
    output logic coreExtIrq,
    output logic coreResetIrq,
    output sipc_pkg::sipc_code_t irqCode,
    output logic irqCodeValid,
    output sipc_pkg::sipc_pins_t pinPending,
    output sipc_pkg::sipc_levels_t levelPending,
    output sipc_pkg::sipc_bus_t bridgePendingVector,
    // Peripheral mode request pin
    output logic irqOut,
    output logic irqOutOe
);
    import sipc_pkg::*;

    sipc_levels_t busLevel;
    sipc_levels_t sysLevel;
    logic [2*`SIPC_NUM_PINS-1:0] rankVec;
    sipc_state_t state;
    sipc_state_t next_state;
    sipc_code_t code;
    sipc_code_t next_code;
    logic codeValid;
    logic next_codeValid;
    logic next_nmi;
    logic ext;
    logic next_ext;
    sipc_pins_t pinsSeen;
    sipc_pins_t next_pinsSeen;
    sipc_levels_t levelsSeen;
    sipc_levels_t next_levelsSeen;

    // Fold of the peripheral bus
    sipc_bus_fold #(
        .BUS_LEVELS(BUS_LEVELS)
    ) u_fold (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .busRequest(busRequest),
        .busLevel(busLevel),
        .bridgePendingVector(bridgePendingVector)
    );

    // Decodes a level select; out-of-range values route nowhere
    function automatic sipc_levels_t selDecode(input sipc_sel_t sel);
        sipc_levels_t d;
        d = '0;
        if (sel < `SIPC_NUM_LEVELS) begin
            d[sel[2:0]] = 1'b1;
        end
        return d;
    endfunction

    // Each internal source onto any one level
    always_comb begin
        sysLevel = '0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (sysSourceReq[i]) begin
                sysLevel = sysLevel | selDecode(sysSourceSel[i*`SIPC_SEL_W +: `SIPC_SEL_W]);
            end
        end
    end

    // Interleave: pin n at rank 2n, level n at rank 2n+1
    always_comb begin
        for (int n = 0; n < `SIPC_NUM_PINS; n++) begin
            rankVec[2*n] = ~irqPin_n[n] & pinEnable[n];
            rankVec[2*n+1] = (busLevel[n] | sysLevel[n]) & levelEnable[n];
        end
    end

    // Priority encoder, highest rank is lowest index
    function automatic sipc_code_t encodeTop(input logic [2*`SIPC_NUM_PINS-1:0] v);
        sipc_code_t c;
        c = `SIPC_CODE_RESET;
        for (int r = 2*`SIPC_NUM_PINS-1; r >= 0; r--) begin
            if (v[r]) begin
                c = sipc_code_t'(r) << `SIPC_CODE_SHIFT;
            end
        end
        return c;
    endfunction

    always_comb begin
        next_pinsSeen = ~irqPin_n & pinEnable;
        next_levelsSeen = (busLevel | sysLevel) & levelEnable;
        // Re-evaluated each clock; only ranks 0..15 can appear
        next_code = encodeTop(rankVec);
        next_codeValid = |rankVec;
        // Watchdog and pin 0 go non-maskable regardless of enables
        next_nmi = (softwareWatchdogExpired & softwareWatchdogIntMode) | ~irqPin_n[0];
        // Fifteen maskable sources onto one line; pin 0 excluded
        next_ext = |rankVec[2*`SIPC_NUM_PINS-1:1];
        if (next_nmi) begin
            next_state = SIPC_NONMASK;
        end else if (next_ext) begin
            next_state = SIPC_MASKABLE;
        end else begin
            next_state = SIPC_IDLE;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state <= SIPC_IDLE;
            code <= `SIPC_CODE_RESET;
            codeValid <= 1'b0;
            ext <= 1'b0;
            pinsSeen <= '0;
            levelsSeen <= '0;
        end else begin
            state <= next_state;
            code <= next_code;
            codeValid <= next_codeValid;
            ext <= next_ext;
            pinsSeen <= next_pinsSeen;
            levelsSeen <= next_levelsSeen;
        end
    end

    // Non-maskable drives the reset interrupt, other requests the external one
    always_comb begin
        case (state)
            SIPC_NONMASK: begin
                coreResetIrq = 1'b1;
                coreExtIrq = ext;
            end
            SIPC_MASKABLE: begin
                coreResetIrq = 1'b0;
                coreExtIrq = 1'b1;
            end
            default: begin
                coreResetIrq = 1'b0;
                coreExtIrq = 1'b0;
            end
        endcase
    end

    assign irqCode = code;
    assign irqCodeValid = codeValid;
    assign pinPending = pinsSeen;
    assign levelPending = levelsSeen;
    // Same combined request mirrored to the pin when enabled
    assign irqOut = coreExtIrq & irqOutEnable;
    assign irqOutOe = irqOutEnable;

    wdogNmi_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (softwareWatchdogExpired && softwareWatchdogIntMode) |=> coreResetIrq)
        else $error("watchdog interrupt did not raise non-maskable");
    pin0Nmi_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (!irqPin_n[0] && rankVec[15:1] == 15'h0000) |=>
        (coreResetIrq && !coreExtIrq))
        else $error("pin 0 request was not non-maskable only");
    extPath_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        coreExtIrq |-> $past(|rankVec[15:1]))
        else $error("external interrupt without maskable source");
    pinRank_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (!irqPin_n[3] && pinEnable[3] && rankVec[5:0] == 6'h00) |=> irqCode == 8'h18)
        else $error("pin 3 not at its fixed rank");
    levelRoute_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (sysSourceReq[0] && sysSourceSel[3:0] == 4'h2 && levelEnable[2]
        && rankVec[4:0] == 5'h00) |=> irqCode == 8'h14)
        else $error("internal source not routed to selected level");
    mergeLine_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (|rankVec[15:1]) |=> coreExtIrq)
        else $error("maskable source not merged onto request line");
    codeTop_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (rankVec[0] == 1'b0 && rankVec[1]) |=> irqCode == 8'h04)
        else $error("level 0 not encoded as rank 1");
    noReserved_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        1'b1 |=> (irqCode[7:6] == 2'b00 && irqCode[1:0] == 2'b00
        && irqCodeValid == $past(|rankVec)))
        else $error("reserved code or stale valid");
    outPin_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        irqOutEnable |-> irqOut == coreExtIrq)
        else $error("request pin differs from core request");
    pendVec_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        1'b1 |=> bridgePendingVector == $past(busRequest))
        else $error("pending vector not tracking bus requests");

    // Non-maskable routing
    wdogResetMode_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (softwareWatchdogExpired && !softwareWatchdogIntMode && irqPin_n[0]) |=> !coreResetIrq)
        else $error("watchdog in reset mode raised non-maskable");
    nmiKeepsExt_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (!irqPin_n[0] && |rankVec[15:1]) |=> (coreResetIrq && coreExtIrq))
        else $error("maskable request lost while non-maskable active");
    resetOnlyNmi_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (irqPin_n[0] && !(softwareWatchdogExpired && softwareWatchdogIntMode)) |=> !coreResetIrq)
        else $error("reset interrupt without non-maskable source");
    extOnly_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (|rankVec[15:1] && irqPin_n[0] && !softwareWatchdogExpired) |=>
        (coreExtIrq && !coreResetIrq))
        else $error("maskable request not taken as external interrupt");
    extIdle_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (rankVec[15:1] == 15'h0000) |=> !coreExtIrq)
        else $error("external interrupt with no maskable source");

    // Fixed ranks, pin n above level n
    pin1Rank_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (!irqPin_n[1] && pinEnable[1] && rankVec[1:0] == 2'h0) |=> irqCode == 8'h08)
        else $error("pin 1 not at its fixed rank");
    pin7Rank_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (!irqPin_n[7] && pinEnable[7] && rankVec[13:0] == 14'h0000) |=> irqCode == 8'h38)
        else $error("pin 7 not at its fixed rank");
    pinOverLevel_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (rankVec[8] && rankVec[9] && rankVec[7:0] == 8'h00) |=> irqCode == 8'h20)
        else $error("pin 4 did not win over level 4");
    levelOverPin_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (rankVec[5] && rankVec[6] && rankVec[4:0] == 5'h00) |=> irqCode == 8'h14)
        else $error("level 2 did not win over pin 3");
    level6Rank_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (rankVec[13] && rankVec[12:0] == 13'h0000) |=> irqCode == 8'h34)
        else $error("level 6 not encoded as rank 13");
    level7Rank_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (rankVec[15] && rankVec[14:0] == 15'h0000) |=> irqCode == 8'h3C)
        else $error("level 7 not encoded as lowest rank");

    // Level routing of internal sources and bus levels
    selLevel0_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (sysSourceReq[0] && sysSourceSel[3:0] == 4'h0) |-> sysLevel[0])
        else $error("source 0 not routed to level 0");
    selLevel7_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (sysSourceReq[7] && sysSourceSel[31:28] == 4'h7) |-> sysLevel[7])
        else $error("source 7 not routed to level 7");
    selNowhere_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (sysSourceReq == 8'h04 && sysSourceSel[11]) |-> sysLevel == 8'h00)
        else $error("out-of-range select reached a level");
    busOneOne_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (bridgePendingVector == 32'h0000_0008) |-> busLevel == 8'h08)
        else $error("bus level 3 not on internal level 3");
    busFoldHigh_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (|bridgePendingVector[31:7]) |-> busLevel[7])
        else $error("upper bus level not folded onto level 7");
    busQuiet_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (bridgePendingVector == 32'h0000_0000) |-> busLevel == 8'h00)
        else $error("internal level set with no bus request");

    // Request output pin
    pinOff_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        !irqOutEnable |-> (!irqOut && !irqOutOe))
        else $error("request pin active while disabled");
    pinFollow_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (irqOutEnable && |rankVec[15:1]) ##1 irqOutEnable |-> irqOut)
        else $error("request pin missed a maskable request");

    // Code and pending outputs track the inputs
    codeIdle_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (rankVec == 16'h0000) |=> (irqCode == `SIPC_CODE_RESET && !irqCodeValid))
        else $error("code shown with nothing pending");
    pinsIdle_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (irqPin_n == 8'hFF) |=> pinPending == 8'h00)
        else $error("pin pending with all pins idle");
    levelsOff_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (levelEnable == 8'h00) |=> levelPending == 8'h00)
        else $error("level pending while all levels disabled");
    masksOff_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (pinEnable == 8'h00 && levelEnable == 8'h00) |=> !irqCodeValid)
        else $error("code valid with every source disabled");
endmodule

// File: src/sipc_pkg.sv
/*
  Types for the interrupt priority controller.
  Assumes sipc_regs.svh is available on the include path.
*/
`include "sipc_regs.svh"

package sipc_pkg;
    typedef logic [`SIPC_NUM_PINS-1:0] sipc_pins_t;
    typedef logic [`SIPC_NUM_LEVELS-1:0] sipc_levels_t;
    typedef logic [`SIPC_NUM_BUS_LEVELS-1:0] sipc_bus_t;
    typedef logic [`SIPC_CODE_W-1:0] sipc_code_t;
    typedef logic [`SIPC_SEL_W-1:0] sipc_sel_t;
    typedef enum logic [1:0] {
        SIPC_IDLE,
        SIPC_MASKABLE,
        SIPC_NONMASK
    } sipc_state_t;
endpackage

// File: src/sipc_regs.svh
/*
  Constants for the interrupt priority controller: source counts, level
  mapping, code layout and timing.
  Assumes inclusion by bare name; definitions only.
*/
`ifndef SIPC_REGS_SVH
`define SIPC_REGS_SVH

`define SIPC_NUM_PINS 8
`define SIPC_NUM_LEVELS 8
`define SIPC_NUM_BUS_LEVELS 32
`define SIPC_FOLD_LEVEL 7
`define SIPC_RANK_W 4
`define SIPC_CODE_W 8
`define SIPC_CODE_SHIFT 2
`define SIPC_SEL_W 4
`define SIPC_SEL_BUS_BASE 8
`define SIPC_CODE_RESET 8'h00
`define SIPC_CLK_PERIOD_NS 8

`endif

// File: verification/sipc_controller_test.sv
/*
  Self-checking bench for the interrupt priority controller.
  Assumes the core model beside it and a 125 MHz ref_clk.
*/
`timescale 1ns/1ps

module sipc_controller_test;
    import sipc_pkg::*;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    sipc_pins_t pinN = 8'hFF;
    logic wdExp = 1'b0;
    logic wdMode = 1'b0;
    logic [7:0] srcReq = 8'h00;
    logic [31:0] srcSel = 32'h0;
    sipc_bus_t busReq = 32'h0;
    sipc_pins_t pinEn = 8'h00;
    sipc_levels_t lvlEn = 8'h00;
    logic outEn = 1'b0;
    logic extIrq, rstIrq, codeVld, irqOut, irqOe;
    sipc_code_t code;
    sipc_pins_t pinPend;
    sipc_levels_t lvlPend;
    sipc_bus_t bpv;
    logic [7:0] rstCnt, extCnt;
    int num_errors = 0;
    int num_checks = 0;

    always #4 ref_clk = ~ref_clk;

    sipc_controller u_dut (.ref_clk(ref_clk), .rstn(rstn), .irqPin_n(pinN),
        .softwareWatchdogExpired(wdExp), .softwareWatchdogIntMode(wdMode),
        .sysSourceReq(srcReq), .sysSourceSel(srcSel), .busRequest(busReq),
        .pinEnable(pinEn), .levelEnable(lvlEn), .irqOutEnable(outEn),
        .coreExtIrq(extIrq), .coreResetIrq(rstIrq), .irqCode(code),
        .irqCodeValid(codeVld), .pinPending(pinPend), .levelPending(lvlPend),
        .bridgePendingVector(bpv), .irqOut(irqOut), .irqOutOe(irqOe));

    sipc_core_model u_core (.ref_clk(ref_clk), .rstn(rstn), .coreExtIrq(extIrq),
        .coreResetIrq(rstIrq), .resetEntries(rstCnt), .extEntries(extCnt));

    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task apply(input logic [7:0] pn, input logic we, wm, input logic [7:0] sr,
        input logic [31:0] sl, br, input logic [7:0] pe, le, input logic oe);
        @(posedge ref_clk);
        pinN <= pn;
        wdExp <= we;
        wdMode <= wm;
        srcReq <= sr;
        srcSel <= sl;
        busReq <= br;
        pinEn <= pe;
        lvlEn <= le;
        outEn <= oe;
    endtask

    task wt(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task t_prio;
        for (int n = 0; n < 8; n++) begin
            apply(~(8'h02 << n), 1'b0, 1'b0, 8'h01, n, 32'h0, 8'hFE, 8'hFF, 1'b1);
            wt(1);
            check(code, 8 * n + 4);
            check(lvlPend, 1 << n);
            check({extIrq, irqOut, irqOe}, 3'h7);
            if (n > 0) begin
                apply(~(8'h01 << n), 1'b0, 1'b0, 8'h01, n, 32'h0, 8'hFE, 8'hFF, 1'b1);
                wt(1);
                check(code, 8 * n);
                check(pinPend, 1 << n);
            end
        end
    endtask

    task t_bus;
        for (int b = 0; b < 32; b++) begin
            apply(8'hFF, 1'b0, 1'b0, 8'h00, 32'h0, 32'h1 << b, 8'hFE, 8'hFF, 1'b1);
            wt(1);
            check(bpv, 32'h1 << b);
            wt(1);
            check(code, 8 * (b < 7 ? b : 7) + 4);
            check(lvlPend, 1 << (b < 7 ? b : 7));
        end
    endtask

    task t_nmi;
        logic [7:0] r0, e0;
        apply(8'hFF, 1'b0, 1'b0, 8'h00, 32'h0, 32'h0, 8'hFE, 8'hFF, 1'b1);
        wt(2);
        r0 = rstCnt;
        e0 = extCnt;
        apply(8'hFF, 1'b1, 1'b1, 8'h00, 32'h0, 32'h0, 8'hFE, 8'hFF, 1'b1);
        wt(1);
        check({rstIrq, extIrq, codeVld}, 3'h4);
        apply(8'hFF, 1'b1, 1'b0, 8'h00, 32'h0, 32'h0, 8'hFE, 8'hFF, 1'b1);
        wt(1);
        check(rstIrq, 1'b0);
        // Pin 0 stays masked as a maskable source
        apply(8'hFE, 1'b0, 1'b0, 8'h00, 32'h0, 32'h0, 8'hFE, 8'hFF, 1'b1);
        wt(1);
        check({rstIrq, extIrq, irqOut}, 3'h4);
        apply(8'hFF, 1'b0, 1'b0, 8'h00, 32'h0, 32'h0, 8'hFE, 8'hFF, 1'b1);
        wt(2);
        check(rstCnt - r0, 8'h02);
        check(extCnt - e0, 8'h00);
        // Pins 0 and 1 together: only the reset entry is taken
        apply(8'hFC, 1'b0, 1'b0, 8'h00, 32'h0, 32'h0, 8'hFE, 8'hFF, 1'b1);
        wt(1);
        check({rstIrq, extIrq, code}, 10'h308);
        check({irqOut, irqOe}, 2'h3);
        wt(1);
        check(extCnt - e0, 8'h00);
        // Back to idle so the next scenario sees a fresh edge
        apply(8'hFF, 1'b0, 1'b0, 8'h00, 32'h0, 32'h0, 8'hFE, 8'hFF, 1'b1);
        wt(1);
    endtask

    task t_mask;
        logic [7:0] e0;
        e0 = extCnt;
        apply(8'h01, 1'b0, 1'b0, 8'hFF, 32'h76543210, 32'h0, 8'hFE, 8'hFF, 1'b0);
        wt(1);
        check({extIrq, code, pinPend, lvlPend}, {1'b1, 8'h04, 8'hFE, 8'hFF});
        check({irqOut, irqOe}, 2'h0);
        wt(1);
        check(extCnt - e0, 8'h01);
        apply(8'hFF, 1'b0, 1'b0, 8'h04, 32'hFFFFFFFF, 32'h0, 8'hFE, 8'hFF, 1'b1);
        wt(1);
        check({extIrq, codeVld, code}, 10'h000);
        apply(8'h01, 1'b0, 1'b0, 8'hFF, 32'h76543210, 32'h0, 8'h00, 8'h00, 1'b1);
        wt(1);
        check({extIrq, codeVld, code, irqOut}, 11'h000);
    endtask

    task close_out;
        $display("checks=%0d errors=%0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        #20000;
        num_errors++;
        close_out();
    end

    initial begin
        repeat (5) @(posedge ref_clk);
        rstn <= 1'b1;
        wt(1);
        check({extIrq, rstIrq, code}, 10'h000);
        t_prio();
        t_bus();
        t_nmi();
        t_mask();
        close_out();
    end
endmodule

// File: verification/sipc_core_model.sv
/*
  Processor core side model: counts entries into the system reset
  interrupt and into the external interrupt.
  Assumes level requests synchronous to ref_clk.
*/
`timescale 1ns/1ps

module sipc_core_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Requests from the controller
    input wire logic coreExtIrq,
    input wire logic coreResetIrq,
    // Entry counts
    output logic [7:0] resetEntries,
    output logic [7:0] extEntries
);
    logic prevExt;
    logic prevRst;
    logic [7:0] next_resetEntries;
    logic [7:0] next_extEntries;

    // Reset entry wins; a maskable edge during it is not taken
    always_comb begin
        next_resetEntries = resetEntries + {7'h00, coreResetIrq & ~prevRst};
        next_extEntries = extEntries + {7'h00, coreExtIrq & ~prevExt & ~coreResetIrq};
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            resetEntries <= 8'h00;
            extEntries <= 8'h00;
            prevExt <= 1'b0;
            prevRst <= 1'b0;
        end else begin
            resetEntries <= next_resetEntries;
            extEntries <= next_extEntries;
            prevExt <= coreExtIrq;
            prevRst <= coreResetIrq;
        end
    end
endmodule
